// ---- design/uds_pkg.sv ----
// register map, field layout and reset values of the serial data and status registers
package uds_pkg;
    // ============================================================
    // register indices and byte addresses
    localparam logic [11:0] DATA_IDX = 12'h0F1;
    localparam logic [11:0] STATUS_IDX = 12'h0F2;
    localparam logic [11:0] DATA_ADDR = {DATA_IDX[9:0], 2'h0};
    localparam logic [11:0] STATUS_ADDR = {STATUS_IDX[9:0], 2'h0};
    localparam logic [11:0] CFG_ADDR = 12'h400;
    localparam logic [11:0] INT_STAT_ADDR = 12'h404;
    localparam logic [11:0] INT_MASK_ADDR = 12'h408;
    // ============================================================
    // line status field positions
    localparam int ST_RX_FULL = 7;
    localparam int ST_PARITY = 6;
    localparam int ST_OVERRUN = 5;
    localparam int ST_FRAMING = 4;
    localparam int ST_BREAK = 3;
    localparam int ST_TX_READY = 2;
    localparam int ST_TX_DONE = 1;
    localparam int ST_NOISE = 0;
    localparam logic [7:0] STATUS_RESET = 8'h02;
    // ============================================================
    // own configuration and interrupt fields
    localparam int CFG_PAR_EN = 0;
    localparam int CFG_PAR_ODD = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam int INT_RX = 0;
    localparam int INT_ERR = 1;
    localparam int INT_TX = 2;
    localparam logic [2:0] INT_RESET = 3'h0;
    // ============================================================
    // bus answers and register selection
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {SEL_NONE, SEL_DATA, SEL_STATUS, SEL_CFG, SEL_INT_STAT, SEL_INT_MASK} uds_sel_e;
endpackage

// ---- design/uds_rx_check.sv ----
// character checks on one received frame: parity, framing and break
`timescale 1ns/1ps
module uds_rx_check (
    input wire logic [7:0] char_data,
    input wire logic parity_bit,
    input wire logic stop_bit,
    input wire logic parity_en,
    input wire logic parity_odd,
    output logic parity_err,
    output logic frame_err,
    output logic break_det
);
    // parity over data plus parity bit is odd for odd parity, even for even parity
    assign parity_err = parity_en & ((^char_data ^ parity_bit) != parity_odd);
    // only the first stop bit is judged; a second one is never looked at [R14]
    assign frame_err = ~stop_bit;
    // break: every bit position of the character low, parity included when present [R15]
    assign break_det = (char_data == 8'h00) & ~stop_bit & ~(parity_en & parity_bit);
endmodule

// ---- design/uds_regs.sv ----
// serial data and line status registers behind an axi4-lite slave
// ============================================================
// Summary of operation
// R1: reading the data register returns the byte in the receive holding register
// R2: any data register access clears the pending receive interrupt
// R3: writing the data register loads the byte for transmission
// R4: a data register read clears parity, overrun, framing and break together
// R5: receive-full sets when a byte lands, clears when the data register is read; the code keeps it set on that read while an overrun is pending
// R6: parity error sets on a failed parity check, clears on data read
// R7: overrun sets on an overrun, clears on data read
// R8: framing error sets on a framing fault, clears on data read
// R9: break sets on a detected line break, clears on data read
// R10: transmit-ready sets when a byte can be taken, clears on data write
// R11: transmit-complete is 0 while shifting, 1 when done, resets to 1
// R12: status bit 0 reads back noise seen on the current byte
// R13: writing status bit 0 turns the noise filter on or off
// R14: framing error when the first stop bit is 0; second stop bit ignored
// R15: break when the line stays low for the whole character
// R16: on overrun the arriving byte is dropped, the stored byte kept
// R17: overrun and break show only after the pending byte is read
// R18: read-clears take effect after the read data is returned
// R19: error bits are captured with the byte they describe
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module uds_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_parity_bit,
    input wire logic rx_stop_bit,
    input wire logic rx_noise,
    input wire logic tx_taken,
    input wire logic tx_busy,
    output logic [7:0] tx_data,
    output logic tx_load,
    output logic noise_filter_en,
    output logic parity_en,
    output logic parity_odd,
    output logic irq
);
    // ============================================================
    // state
    typedef struct packed {
        logic aw_got;
        logic [11:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] rx_hold;
        logic [7:0] status;
        logic pend_ovr;
        logic pend_brk;
        logic nf_en;
        logic [1:0] cfg;
        logic [7:0] tx_data;
        logic tx_pending;
        logic [2:0] int_stat;
        logic [2:0] int_mask;
        logic irq;
    } uds_state_s;

    uds_state_s q;
    uds_state_s next_q;
    logic chk_perr;
    logic chk_ferr;
    logic chk_brk;
    logic wr_fire;
    logic rd_fire;
    uds_pkg::uds_sel_e wr_sel;
    uds_pkg::uds_sel_e rd_sel;

    // address decode shared by the read and write paths
    function automatic uds_pkg::uds_sel_e decode(input logic [11:0] addr);
        unique case (addr)
            uds_pkg::DATA_ADDR: decode = uds_pkg::SEL_DATA;
            uds_pkg::STATUS_ADDR: decode = uds_pkg::SEL_STATUS;
            uds_pkg::CFG_ADDR: decode = uds_pkg::SEL_CFG;
            uds_pkg::INT_STAT_ADDR: decode = uds_pkg::SEL_INT_STAT;
            uds_pkg::INT_MASK_ADDR: decode = uds_pkg::SEL_INT_MASK;
            default: decode = uds_pkg::SEL_NONE;
        endcase
    endfunction

    uds_rx_check u_check (
        .char_data(rx_char_data),
        .parity_bit(rx_parity_bit),
        .stop_bit(rx_stop_bit),
        .parity_en(q.cfg[uds_pkg::CFG_PAR_EN]),
        .parity_odd(q.cfg[uds_pkg::CFG_PAR_ODD]),
        .parity_err(chk_perr),
        .frame_err(chk_ferr),
        .break_det(chk_brk)
    );

    // a write runs once both address and data are held and the last answer is gone
    assign wr_fire = q.aw_got & q.w_got & ~q.bvalid;
    assign rd_fire = s_axi_arvalid & q.arready;
    assign wr_sel = decode(q.aw_addr);
    assign rd_sel = decode(s_axi_araddr);

    // ============================================================
    // next state
    always_comb begin
        logic data_rd;
        logic data_wr;
        logic [2:0] ev;
        data_rd = rd_fire & (rd_sel == uds_pkg::SEL_DATA);
        data_wr = wr_fire & (wr_sel == uds_pkg::SEL_DATA) & q.w_lane0;
        ev = 3'h0;
        next_q = q;
        // write address and data are taken in either order
        if (s_axi_awvalid & q.awready) begin
            next_q.aw_got = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & q.wready) begin
            next_q.w_got = 1'b1;
            next_q.w_data = s_axi_wdata[7:0];
            next_q.w_lane0 = s_axi_wstrb[0];
        end
        if (q.bvalid & s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = (wr_sel == uds_pkg::SEL_NONE) ? uds_pkg::RESP_SLVERR : uds_pkg::RESP_OKAY;
            if (q.w_lane0) begin
                unique case (wr_sel)
                    uds_pkg::SEL_STATUS: next_q.nf_en = q.w_data[uds_pkg::ST_NOISE]; // [R13]
                    uds_pkg::SEL_CFG: next_q.cfg = q.w_data[1:0];
                    uds_pkg::SEL_INT_STAT: next_q.int_stat = q.int_stat & ~q.w_data[2:0];
                    uds_pkg::SEL_INT_MASK: next_q.int_mask = q.w_data[2:0];
                    default: begin
                    end
                endcase
            end
        end
        // read: data latched from the current state, so the clearing below lands afterwards [R18]
        if (q.rvalid & s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = (rd_sel == uds_pkg::SEL_NONE) ? uds_pkg::RESP_SLVERR : uds_pkg::RESP_OKAY;
            unique case (rd_sel)
                uds_pkg::SEL_DATA: next_q.rdata = {24'h000000, q.rx_hold}; // [R1]
                uds_pkg::SEL_STATUS: next_q.rdata = {24'h000000, q.status}; // [R12]
                uds_pkg::SEL_CFG: next_q.rdata = {30'h00000000, q.cfg};
                uds_pkg::SEL_INT_STAT: next_q.rdata = {29'h00000000, q.int_stat};
                uds_pkg::SEL_INT_MASK: next_q.rdata = {29'h00000000, q.int_mask};
                default: next_q.rdata = 32'h00000000;
            endcase
        end
        // a data read empties the holder and its error bits; a withheld overrun shows now and keeps receive-full set
        if (data_rd) begin
            next_q.status[uds_pkg::ST_RX_FULL] = q.pend_ovr; // [R5]
            next_q.status[uds_pkg::ST_PARITY] = 1'b0; // [R4] [R6]
            next_q.status[uds_pkg::ST_OVERRUN] = q.pend_ovr; // [R7] [R17]
            next_q.status[uds_pkg::ST_FRAMING] = 1'b0; // [R8]
            next_q.status[uds_pkg::ST_BREAK] = q.pend_ovr & q.pend_brk; // [R9] [R17]
            next_q.status[uds_pkg::ST_NOISE] = 1'b0;
            next_q.pend_ovr = 1'b0;
            next_q.pend_brk = 1'b0;
            ev[uds_pkg::INT_ERR] = q.pend_ovr;
        end
        // an arriving character wins over a read in the same cycle
        if (rx_char_valid) begin
            if (next_q.status[uds_pkg::ST_RX_FULL]) begin
                next_q.pend_ovr = 1'b1; // byte dropped, holder kept [R16]
                next_q.pend_brk = next_q.pend_brk | chk_brk;
            end else begin
                next_q.rx_hold = rx_char_data;
                next_q.status[uds_pkg::ST_RX_FULL] = 1'b1; // [R5]
                next_q.status[uds_pkg::ST_PARITY] = chk_perr; // [R6] [R19]
                next_q.status[uds_pkg::ST_FRAMING] = chk_ferr; // [R8] [R14] [R19]
                next_q.status[uds_pkg::ST_BREAK] = chk_brk; // [R9] [R15] [R19]
                next_q.status[uds_pkg::ST_OVERRUN] = 1'b0;
                next_q.status[uds_pkg::ST_NOISE] = rx_noise; // [R12]
                ev[uds_pkg::INT_RX] = 1'b1;
                ev[uds_pkg::INT_ERR] = chk_perr | chk_ferr | chk_brk;
            end
        end
        // transmit holding: a write loads the byte and holds the request till the shifter takes it
        if (tx_taken) begin
            next_q.tx_pending = 1'b0;
        end
        if (data_wr) begin
            next_q.tx_data = q.w_data; // [R3]
            next_q.tx_pending = 1'b1;
            next_q.status[uds_pkg::ST_TX_READY] = 1'b0; // [R10]
        end else if (tx_taken | (~q.tx_pending & ~tx_busy)) begin
            next_q.status[uds_pkg::ST_TX_READY] = 1'b1; // [R10]
        end
        next_q.status[uds_pkg::ST_TX_DONE] = ~tx_busy & ~next_q.tx_pending; // [R11]
        ev[uds_pkg::INT_TX] = next_q.status[uds_pkg::ST_TX_READY] & ~q.status[uds_pkg::ST_TX_READY];
        // any data access drops the receive interrupt; a new event in the same cycle wins
        if (rd_fire & (rd_sel == uds_pkg::SEL_DATA)) begin
            next_q.int_stat[uds_pkg::INT_RX] = 1'b0; // [R2]
        end
        if (wr_fire & (wr_sel == uds_pkg::SEL_DATA)) begin
            next_q.int_stat[uds_pkg::INT_RX] = 1'b0; // [R2]
        end
        next_q.int_stat = next_q.int_stat | ev;
        next_q.irq = |(next_q.int_stat & next_q.int_mask);
        // ready flops track the holding state so every output comes from a register
        next_q.awready = ~next_q.aw_got & ~next_q.bvalid;
        next_q.wready = ~next_q.w_got & ~next_q.bvalid;
        next_q.arready = ~next_q.rvalid;
    end

    // ============================================================
    // registers; clock enable low freezes everything except the synchronous reset, which still loads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.status <= uds_pkg::STATUS_RESET; // [R11]
            q.cfg <= uds_pkg::CFG_RESET;
            q.int_stat <= uds_pkg::INT_RESET;
            q.int_mask <= uds_pkg::INT_RESET;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else if (ce) begin
            q <= next_q;
        end
    end

    // ============================================================
    // outputs
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign tx_data = q.tx_data;
    assign tx_load = q.tx_pending;
    assign noise_filter_en = q.nf_en;
    assign parity_en = q.cfg[uds_pkg::CFG_PAR_EN];
    assign parity_odd = q.cfg[uds_pkg::CFG_PAR_ODD];
    assign irq = q.irq;

    // ============================================================
    // checks
    logic rd_data_hs;
    logic wr_data_hs;
    assign rd_data_hs = ce & rd_fire & (rd_sel == uds_pkg::SEL_DATA);
    assign wr_data_hs = ce & wr_fire & (wr_sel == uds_pkg::SEL_DATA) & q.w_lane0;

    sequence s_overrun_hit;
        ce & rx_char_valid & q.status[uds_pkg::ST_RX_FULL] & ~rd_data_hs;
    endsequence
    sequence s_clean_read;
        rd_data_hs & ~rx_char_valid & ~q.pend_ovr;
    endsequence

    AST_RX_DATA_RETURNED: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
        rd_data_hs |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(q.rx_hold))
        else $error("data read did not return the held byte");
    AST_RX_INT_CLEARED: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        s_clean_read |=> !q.int_stat[uds_pkg::INT_RX])
        else $error("data access left receive interrupt pending");
    AST_TX_LOADED: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        wr_data_hs |=> tx_load && tx_data == $past(q.w_data) && !s_axi_awready)
        else $error("data write did not load transmit byte");
    AST_ERR_CLEARED: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        s_clean_read |=> q.status[6:3] == 4'h0 && !q.status[uds_pkg::ST_RX_FULL])
        else $error("data read left error or full bits set");
    AST_FRAME_CAPTURED: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        ce && rx_char_valid && !q.status[uds_pkg::ST_RX_FULL]
        |=> q.status[uds_pkg::ST_FRAMING] == !$past(rx_stop_bit) && q.rx_hold == $past(rx_char_data))
        else $error("framing bit not captured with byte");
    AST_OVERRUN_DISCARD: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
        s_overrun_hit |=> q.rx_hold == $past(q.rx_hold) && q.pend_ovr
            && q.status[uds_pkg::ST_OVERRUN] == $past(q.status[uds_pkg::ST_OVERRUN]))
        else $error("overrun byte overwrote holder or showed early");
    AST_OVERRUN_SHOWN: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
        rd_data_hs && q.pend_ovr && !rx_char_valid |=> q.status[uds_pkg::ST_OVERRUN] && q.status[uds_pkg::ST_RX_FULL])
        else $error("withheld overrun not shown after read");
    AST_TX_READY_CLEARED: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        wr_data_hs |=> !q.status[uds_pkg::ST_TX_READY] ##1 ($past(tx_taken) || q.tx_pending))
        else $error("transmit ready not cleared by data write");
    AST_TX_DONE_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        ce && tx_busy |=> !q.status[uds_pkg::ST_TX_DONE])
        else $error("transmit complete high while shifting");
    AST_NOISE_FILTER: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
        ce && wr_fire && wr_sel == uds_pkg::SEL_STATUS && q.w_lane0 |=> noise_filter_en == $past(q.w_data[0]))
        else $error("noise filter enable not written");
endmodule

// ---- test/uds_line_model.sv ----
// line-side model: receive and transmit shifters facing the serial registers
`timescale 1ns/1ps
module uds_line_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_load,
    input wire logic [7:0] tx_lag,
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic rx_parity_bit,
    output logic rx_stop_bit,
    output logic rx_noise,
    output logic tx_taken,
    output logic tx_busy
);
    int cnt = 0;
    // ==========================================================
    // receive side
    // fields mean something only in the pulse cycle; they flip afterwards
    // so a design that samples them late reads garbage
    task automatic send(input logic [7:0] d, input logic p, s, n);
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        rx_parity_bit <= p;
        rx_stop_bit <= s;
        rx_noise <= n;
        @(posedge aclk);
        rx_char_valid <= 1'b0;
        {rx_char_data, rx_parity_bit, rx_stop_bit, rx_noise} <= ~{d, p, s, n};
        @(posedge aclk);
    endtask
    initial begin
        {rx_char_valid, rx_char_data, rx_parity_bit, rx_stop_bit, rx_noise} = '0;
    end
    // ==========================================================
    // transmit side
    // takes the byte tx_lag+1 cycles after it sees the load, then shifts 11 cycles;
    // a large lag keeps a byte pending so the bench can see it waiting
    always @(posedge aclk) begin
        if (!aresetn)
            cnt = 0;
        else if (cnt > 0)
            cnt = cnt - 1;
        else if (tx_load)
            cnt = int'(tx_lag) + 12;
        tx_taken <= (cnt == 11);
        tx_busy <= (cnt > 0 && cnt <= 11);
    end
endmodule

// ---- test/tb_uart_data_and_status_regs.sv ----
// self-checking bench for the serial data and status registers
`timescale 1ns/1ps
module tb_uart_data_and_status_regs;
    localparam logic [11:0] st_addr = uds_pkg::STATUS_ADDR;
    localparam logic [11:0] dt_addr = uds_pkg::DATA_ADDR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [7:0] lag = 8'h00, d, e;
    logic awready, wready, bvalid, arready, rvalid, rxv, rxp, rxs, rxn, txt, txb, txl, nfe, pen, podd, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] rxd, txd;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    logic [7:0] tq[$];
    int err_total = 0, n_tests = 0, cyc = 0;

    uds_regs dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_char_valid(rxv),
        .rx_char_data(rxd), .rx_parity_bit(rxp), .rx_stop_bit(rxs), .rx_noise(rxn), .tx_taken(txt),
        .tx_busy(txb), .tx_data(txd), .tx_load(txl), .noise_filter_en(nfe), .parity_en(pen),
        .parity_odd(podd), .irq(irq));
    uds_line_model line (.aclk(aclk), .aresetn(aresetn), .tx_load(txl), .tx_lag(lag), .rx_char_valid(rxv),
        .rx_char_data(rxd), .rx_parity_bit(rxp), .rx_stop_bit(rxs), .rx_noise(rxn), .tx_taken(txt),
        .tx_busy(txb));

    always #10 aclk = ~aclk;
    // ==========================================================
    // checking and verdict
    task automatic fail(input logic bad, input string what);
        n_tests++;
        if (bad !== 1'b0) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic cmp_rd(input logic [33:0] g, x);
        fail(g !== x, "read response or data");
    endtask
    task automatic cmp_wr(input logic [1:0] g, x);
        fail(g !== x, "write response");
    endtask
    task automatic cmp_tx(input logic [7:0] g, x);
        fail(g !== x, "transmitted byte");
    endtask
    task automatic cmp_lvl(input logic g, x);
        fail(g !== x, "output level");
    endtask
    task automatic close_out();
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // result watcher: each answer takes the oldest expectation off its queue
    always @(posedge aclk) begin
        if (rvalid && rready) cmp_rd({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) cmp_wr(bresp, wq.pop_front());
        if (txt) cmp_tx(txd, tq.pop_front());
    end
    // hang guard: the sequence needs well under two thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    // ==========================================================
    // bus master; one edge passes after each transfer so no signal is driven twice in a step
    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] r = uds_pkg::RESP_OKAY);
        wq.push_back(r);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] v, input logic [1:0] r = uds_pkg::RESP_OKAY);
        rq.push_back({r, 24'h000000, v});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask
    // software must not load a byte while the transmitter is still busy
    task automatic idle();
        for (int t = 0; t < 200 && (txl || txb); t++) @(posedge aclk);
        settle();
    endtask
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(53831));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(st_addr, 8'h06);
        rd(uds_pkg::INT_STAT_ADDR, 8'h04);
        rd(uds_pkg::INT_MASK_ADDR, 8'h00);
        rd(uds_pkg::CFG_ADDR, 8'h00);
        cmp_lvl(irq, 1'b0);
        // plain byte with noise, then a framing fault
        d = 8'($urandom) | 8'h01; // nonzero: the framing case below must not read as a break
        line.send(d, 1'b0, 1'b1, 1'b1);
        rd(st_addr, 8'h87);
        rd(dt_addr, d);
        rd(st_addr, 8'h06);
        line.send(d, 1'b0, 1'b0, 1'b0);
        rd(st_addr, 8'h96);
        rd(dt_addr, d);
        rd(st_addr, 8'h06);
        // even then odd parity with the same wrong-for-even bit
        for (int m = 0; m < 2; m++) begin
            d = 8'($urandom);
            wr(uds_pkg::CFG_ADDR, 8'(2 * m + 1));
            cmp_lvl(pen, 1'b1);
            cmp_lvl(podd, 1'(m));
            line.send(d, ~^d, 1'b1, 1'b0);
            rd(st_addr, m ? 8'h86 : 8'hC6);
            rd(dt_addr, d);
            rd(st_addr, 8'h06);
        end
        wr(uds_pkg::CFG_ADDR, 8'h00);
        line.send(8'h00, 1'b0, 1'b0, 1'b0);
        rd(st_addr, 8'h9E);
        rd(dt_addr, 8'h00);
        rd(st_addr, 8'h06);
        // overrun: second byte dropped, flag withheld until first read
        d = 8'($urandom);
        e = 8'($urandom);
        line.send(d, 1'b0, 1'b1, 1'b0);
        line.send(e, 1'b0, 1'b1, 1'b0);
        rd(st_addr, 8'h86);
        rd(dt_addr, d);
        rd(st_addr, 8'hA6);
        rd(dt_addr, d);
        rd(st_addr, 8'h06);
        // transmit with a prompt and a slow shifter
        for (int i = 0; i < 2; i++) begin
            lag <= 8'(8 * i);
            d = 8'($urandom);
            tq.push_back(d);
            wr(dt_addr, d);
            if (i == 1) rd(st_addr, 8'h00);
            if (i == 1) cmp_lvl(txl, 1'b1);
            idle();
            rd(st_addr, 8'h06);
        end
        // noise filter enable is write-only, reads show the noise flag
        wr(st_addr, 8'h01);
        cmp_lvl(nfe, 1'b1);
        rd(st_addr, 8'h06);
        wr(st_addr, 8'hFE);
        cmp_lvl(nfe, 1'b0);
        // interrupt: raise, clear by data read and by data write, mask, write-one-clear
        wr(uds_pkg::INT_STAT_ADDR, 8'h07);
        wr(uds_pkg::INT_MASK_ADDR, 8'h01);
        d = 8'($urandom);
        line.send(d, 1'b0, 1'b1, 1'b0);
        settle();
        cmp_lvl(irq, 1'b1);
        rd(dt_addr, d);
        settle();
        cmp_lvl(irq, 1'b0);
        line.send(d, 1'b0, 1'b1, 1'b0);
        settle();
        cmp_lvl(irq, 1'b1);
        tq.push_back(e);
        wr(dt_addr, e);
        settle();
        cmp_lvl(irq, 1'b0);
        idle();
        rd(dt_addr, d);
        wr(uds_pkg::INT_MASK_ADDR, 8'h04);
        settle();
        cmp_lvl(irq, 1'b1);
        wr(uds_pkg::INT_STAT_ADDR, 8'h04);
        settle();
        cmp_lvl(irq, 1'b0);
        // unmapped place answers with an error and changes nothing
        rd(12'h100, 8'h00, uds_pkg::RESP_SLVERR);
        wr(12'h100, 8'h5A, uds_pkg::RESP_SLVERR);
        rd(st_addr, 8'h06);
        fail(tq.size() != 0, "byte never taken");
        close_out();
    end
endmodule
